//--- common/srfc_regs.vh
`ifndef SRFC_REGS_VH
`define SRFC_REGS_VH

// ============================================================
// Register indices and byte addresses
`define SRFC_IDX_RATE_DIV 8'h19
`define SRFC_IDX_CONFIG 8'h1A
`define SRFC_IDX_GYRO_CFG 8'h1B
`define SRFC_IDX_STATUS 8'h20
`define SRFC_ADDR_RATE_DIV 8'h64
`define SRFC_ADDR_CONFIG 8'h68
`define SRFC_ADDR_GYRO_CFG 8'h6C
`define SRFC_ADDR_STATUS 8'h80

// ============================================================
// Field positions and reset values
`define SRFC_CFG_MODE_BIT 6
`define SRFC_CFG_SYNC_HI 5
`define SRFC_CFG_SYNC_LO 3
`define SRFC_CFG_LPF_HI 2
`define SRFC_CFG_LPF_LO 0
`define SRFC_GCFG_BYP_HI 1
`define SRFC_GCFG_BYP_LO 0
`define SRFC_RST_RATE_DIV 8'h00
`define SRFC_RST_CONFIG 7'h00
`define SRFC_RST_GYRO_CFG 2'h0

// ============================================================
// Rates, bandwidths and timing
`define SRFC_CLK_HZ 50000000
`define SRFC_RATE_1K_HZ 1000
`define SRFC_RATE_8K_HZ 8000
`define SRFC_RATE_32K_HZ 32000
`define SRFC_RCODE_1K 2'h0
`define SRFC_RCODE_8K 2'h1
`define SRFC_RCODE_32K 2'h2
`define SRFC_BW_BYP_WIDE 14'h1FED
`define SRFC_BW_BYP_MID 14'h0CD1
`define SRFC_BW_CFG0 14'h00FA
`define SRFC_BW_CFG1 14'h00B0
`define SRFC_BW_CFG2 14'h005C
`define SRFC_BW_CFG3 14'h0029
`define SRFC_BW_CFG4 14'h0014
`define SRFC_BW_CFG5 14'h000A
`define SRFC_BW_CFG6 14'h0005
`define SRFC_LPF_MAX 3'h7

// ============================================================
// Bus answers
`define SRFC_RESP_OKAY 2'h0
`define SRFC_RESP_SLVERR 2'h2

`endif

//--- hw/srfc_top.v
`timescale 1ns/1ns
`include "srfc_regs.vh"

// ============================================================
// Sample FIFO with drop or overwrite policy when full
module srfc_fifo #(
  parameter WIDTH = 112,
  parameter DEPTH = 8,
  parameter AW = 3
) (
  input wire aclk,
  input wire aresetn,
  input wire overwrite,
  input wire in_valid,
  output wire in_ready,
  input wire [WIDTH-1:0] in_data,
  output wire out_valid,
  input wire out_ready,
  output wire [WIDTH-1:0] out_data,
  output wire [AW:0] level
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wptr_ff;
  reg [AW-1:0] rptr_ff;
  reg [AW:0] cnt_ff;
  wire full = (cnt_ff == DEPTH[AW:0]);
  wire empty = (cnt_ff == {(AW+1){1'b0}});
  wire pop = out_valid & out_ready;
  // Full and overwrite: a write still lands and the oldest entry is pushed out
  wire push = in_valid & in_ready;
  wire evict = push & full & ~pop;
  assign in_ready = ~full | overwrite | out_ready;
  assign out_valid = ~empty;
  assign out_data = mem[rptr_ff];
  assign level = cnt_ff;

  always @(posedge aclk) begin
    if (push) begin
      mem[wptr_ff] <= in_data;
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      wptr_ff <= {AW{1'b0}};
      rptr_ff <= {AW{1'b0}};
      cnt_ff <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wptr_ff <= (wptr_ff == DEPTH - 1) ? {AW{1'b0}} : wptr_ff + 1'b1;
      end
      if (pop | evict) begin
        rptr_ff <= (rptr_ff == DEPTH - 1) ? {AW{1'b0}} : rptr_ff + 1'b1;
      end
      if (push & ~pop & ~full) begin
        cnt_ff <= cnt_ff + 1'b1;
      end else if (pop & ~push) begin
        cnt_ff <= cnt_ff - 1'b1;
      end
    end
  end
endmodule

// ============================================================
// Rate divider, filter configuration and sync capture
module srfc_top #(
  parameter PER_1K = `SRFC_CLK_HZ / `SRFC_RATE_1K_HZ,
  parameter PER_8K = `SRFC_CLK_HZ / `SRFC_RATE_8K_HZ,
  parameter PER_32K = `SRFC_CLK_HZ / `SRFC_RATE_32K_HZ,
  parameter FIFO_DEPTH = 8,
  parameter FIFO_AW = 3
) (
  input wire aclk,
  input wire aresetn,
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output wire [1:0] s_axi_bresp,
  output wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output wire [31:0] s_axi_rdata,
  output wire [1:0] s_axi_rresp,
  output wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire frame_sync_input,
  input wire [15:0] temp_in,
  input wire [15:0] rot_x_in,
  input wire [15:0] rot_y_in,
  input wire [15:0] rot_z_in,
  input wire [15:0] accel_x_in,
  input wire [15:0] accel_y_in,
  input wire [15:0] accel_z_in,
  output wire [15:0] temp_out,
  output wire [15:0] rot_x_out,
  output wire [15:0] rot_y_out,
  output wire [15:0] rot_z_out,
  output wire [15:0] accel_x_out,
  output wire [15:0] accel_y_out,
  output wire [15:0] accel_z_out,
  output wire sample_strobe,
  output wire [2:0] lowpass_setting_eff,
  output wire [1:0] rate_code,
  output wire [13:0] bandwidth_hz,
  output wire fifo_out_valid,
  input wire fifo_out_ready,
  output wire [111:0] fifo_out_data
);
  // ============================================================
  // Registers
  reg [7:0] rate_divider_value_ff;
  reg [6:0] config_ff;
  reg [1:0] filter_bypass_select_ff;
  reg aw_got_ff;
  reg w_got_ff;
  reg [7:0] awaddr_ff;
  reg [31:0] wdata_ff;
  reg wstrb0_ff;
  reg bvalid_ff;
  reg [1:0] bresp_ff;
  reg rvalid_ff;
  reg [31:0] rdata_ff;
  reg [1:0] rresp_ff;
  reg [15:0] base_cnt_ff;
  reg [7:0] div_cnt_ff;
  reg strobe_ff;
  reg sync_latched_ff;
  reg sync_armed_ff;
  reg [111:0] out_ff;
  reg fifo_drop_ff;
  reg [15:0] period;
  reg [13:0] bw;
  reg [1:0] rcode;
  reg [31:0] nxt_rdata;
  reg [1:0] nxt_rresp;
  wire [FIFO_AW:0] fifo_level;
  wire fifo_in_ready;
  wire [111:0] in_all;
  wire [111:0] nxt_out;
  wire fifo_mode = config_ff[`SRFC_CFG_MODE_BIT];
  wire [2:0] sync_bit_select = config_ff[`SRFC_CFG_SYNC_HI:`SRFC_CFG_SYNC_LO];
  wire [2:0] lowpass_setting = config_ff[`SRFC_CFG_LPF_HI:`SRFC_CFG_LPF_LO];
  wire div_active = (filter_bypass_select_ff == 2'h0) && (lowpass_setting != 3'h0) &&
                    (lowpass_setting != `SRFC_LPF_MAX);
  wire base_tick = (base_cnt_ff == period - 16'h0001);
  wire sync_toggle = sync_armed_ff & (frame_sync_input != sync_latched_ff);

  // ============================================================
  // Bus slave: one write and one read at a time
  wire wr_fire = aw_got_ff & w_got_ff & ~bvalid_ff;
  assign s_axi_awready = ~aw_got_ff & ~bvalid_ff;
  assign s_axi_wready = ~w_got_ff & ~bvalid_ff;
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;
  assign s_axi_arready = ~rvalid_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata = rdata_ff;
  assign s_axi_rresp = rresp_ff;

  always @* begin
    nxt_rresp = `SRFC_RESP_OKAY;
    case (s_axi_araddr)
      `SRFC_ADDR_RATE_DIV: nxt_rdata = {24'h000000, rate_divider_value_ff};
      `SRFC_ADDR_CONFIG: nxt_rdata = {25'h0000000, config_ff};
      `SRFC_ADDR_GYRO_CFG: nxt_rdata = {30'h00000000, filter_bypass_select_ff};
      `SRFC_ADDR_STATUS: nxt_rdata = {4'h0, fifo_level, 5'h00, fifo_drop_ff, sync_latched_ff,
                                      div_active, rcode, bw};
      default: begin
        nxt_rdata = 32'h00000000;
        nxt_rresp = `SRFC_RESP_SLVERR;
      end
    endcase
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_ff <= 1'b0;
      w_got_ff <= 1'b0;
      awaddr_ff <= 8'h00;
      wdata_ff <= 32'h00000000;
      wstrb0_ff <= 1'b0;
      bvalid_ff <= 1'b0;
      bresp_ff <= `SRFC_RESP_OKAY;
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h00000000;
      rresp_ff <= `SRFC_RESP_OKAY;
      rate_divider_value_ff <= `SRFC_RST_RATE_DIV;
      config_ff <= `SRFC_RST_CONFIG;
      filter_bypass_select_ff <= `SRFC_RST_GYRO_CFG;
    end else begin
      if (s_axi_awvalid & s_axi_awready) begin
        aw_got_ff <= 1'b1;
        awaddr_ff <= s_axi_awaddr;
      end
      if (s_axi_wvalid & s_axi_wready) begin
        w_got_ff <= 1'b1;
        wdata_ff <= s_axi_wdata;
        wstrb0_ff <= s_axi_wstrb[0];
      end
      if (wr_fire) begin
        aw_got_ff <= 1'b0;
        w_got_ff <= 1'b0;
        bvalid_ff <= 1'b1;
        bresp_ff <= `SRFC_RESP_OKAY;
        case (awaddr_ff)
          `SRFC_ADDR_RATE_DIV: begin
            if (wstrb0_ff) begin
              rate_divider_value_ff <= wdata_ff[7:0];
            end
          end
          `SRFC_ADDR_CONFIG: begin
            // Top bit is kept at zero, so only seven bits are stored
            if (wstrb0_ff) begin
              config_ff <= wdata_ff[6:0];
            end
          end
          `SRFC_ADDR_GYRO_CFG: begin
            if (wstrb0_ff) begin
              filter_bypass_select_ff <= wdata_ff[`SRFC_GCFG_BYP_HI:`SRFC_GCFG_BYP_LO];
            end
          end
          `SRFC_ADDR_STATUS: begin
          end
          default: begin
            bresp_ff <= `SRFC_RESP_SLVERR;
          end
        endcase
      end else if (bvalid_ff & s_axi_bready) begin
        bvalid_ff <= 1'b0;
      end
      if (s_axi_arvalid & s_axi_arready) begin
        rvalid_ff <= 1'b1;
        rdata_ff <= nxt_rdata;
        rresp_ff <= nxt_rresp;
      end else if (rvalid_ff & s_axi_rready) begin
        rvalid_ff <= 1'b0;
      end
    end
  end

  // ============================================================
  // Filter selection: internal rate and bandwidth
  always @* begin
    if (filter_bypass_select_ff[0]) begin
      rcode = `SRFC_RCODE_32K;
      bw = `SRFC_BW_BYP_WIDE;
    end else if (filter_bypass_select_ff[1]) begin
      rcode = `SRFC_RCODE_32K;
      bw = `SRFC_BW_BYP_MID;
    end else begin
      rcode = div_active ? `SRFC_RCODE_1K : `SRFC_RCODE_8K;
      case (lowpass_setting)
        3'h0: bw = `SRFC_BW_CFG0;
        3'h1: bw = `SRFC_BW_CFG1;
        3'h2: bw = `SRFC_BW_CFG2;
        3'h3: bw = `SRFC_BW_CFG3;
        3'h4: bw = `SRFC_BW_CFG4;
        3'h5: bw = `SRFC_BW_CFG5;
        3'h6: bw = `SRFC_BW_CFG6;
        default: bw = `SRFC_BW_BYP_MID;
      endcase
    end
    case (rcode)
      `SRFC_RCODE_1K: period = PER_1K[15:0];
      `SRFC_RCODE_8K: period = PER_8K[15:0];
      default: period = PER_32K[15:0];
    endcase
  end

  assign rate_code = rcode;
  assign bandwidth_hz = bw;
  assign lowpass_setting_eff = (filter_bypass_select_ff == 2'h0) ? lowpass_setting : 3'h0;

  // ============================================================
  // Internal rate tick and divided sample strobe
  always @(posedge aclk) begin
    if (!aresetn) begin
      base_cnt_ff <= 16'h0000;
      div_cnt_ff <= 8'h00;
      strobe_ff <= 1'b0;
    end else begin
      // Period shrinking below the count restarts the count rather than wrapping
      base_cnt_ff <= (base_tick || base_cnt_ff >= period) ? 16'h0000 : base_cnt_ff + 16'h0001;
      strobe_ff <= 1'b0;
      if (base_tick) begin
        if (!div_active) begin
          div_cnt_ff <= 8'h00;
          strobe_ff <= 1'b1;
        end else if (div_cnt_ff >= rate_divider_value_ff) begin
          div_cnt_ff <= 8'h00;
          strobe_ff <= 1'b1;
        end else begin
          div_cnt_ff <= div_cnt_ff + 8'h01;
        end
      end
    end
  end

  assign sample_strobe = strobe_ff;

  // ============================================================
  // Sync latch: one toggle, then held until the strobe takes it
  always @(posedge aclk) begin
    if (!aresetn) begin
      sync_latched_ff <= 1'b0;
      sync_armed_ff <= 1'b1;
    end else begin
      if (sync_toggle) begin
        sync_latched_ff <= frame_sync_input;
      end
      // A toggle in the strobe cycle stays locked so it is not overwritten unseen
      sync_armed_ff <= sync_toggle ? 1'b0 : (strobe_ff ? 1'b1 : sync_armed_ff);
    end
  end

  // ============================================================
  // Output registers with sync bit insertion
  assign in_all = {accel_z_in, accel_y_in, accel_x_in, rot_z_in, rot_y_in, rot_x_in, temp_in};

  genvar gi;
  generate
    for (gi = 0; gi < 7; gi = gi + 1) begin : g_chan
      assign nxt_out[gi*16+15:gi*16+1] = in_all[gi*16+15:gi*16+1];
      assign nxt_out[gi*16] = (sync_bit_select == gi + 1) ? sync_latched_ff : in_all[gi*16];
    end
  endgenerate

  always @(posedge aclk) begin
    if (!aresetn) begin
      out_ff <= {112{1'b0}};
      fifo_drop_ff <= 1'b0;
    end else begin
      if (strobe_ff) begin
        out_ff <= nxt_out;
      end
      if (strobe_ff & ~fifo_in_ready) begin
        fifo_drop_ff <= 1'b1;
      end
    end
  end

  assign temp_out = out_ff[15:0];
  assign rot_x_out = out_ff[31:16];
  assign rot_y_out = out_ff[47:32];
  assign rot_z_out = out_ff[63:48];
  assign accel_x_out = out_ff[79:64];
  assign accel_y_out = out_ff[95:80];
  assign accel_z_out = out_ff[111:96];

  // ============================================================
  // Sample FIFO, written on the strobe with the same word as the outputs
  srfc_fifo #(
    .WIDTH(112),
    .DEPTH(FIFO_DEPTH),
    .AW(FIFO_AW)
  ) u_fifo (
    .aclk(aclk),
    .aresetn(aresetn),
    .overwrite(~fifo_mode),
    .in_valid(strobe_ff),
    .in_ready(fifo_in_ready),
    .in_data(nxt_out),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_out_ready),
    .out_data(fifo_out_data),
    .level(fifo_level)
  );
endmodule

//--- dv/srfc_sva.sv
`timescale 1ns/1ns
// ============================================================
// Port checker
module srfc_sva (
  input wire aclk,
  input wire aresetn,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire [1:0] s_axi_bresp,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire [15:0] rot_x_in,
  input wire [15:0] rot_x_out,
  input wire [15:0] rot_y_out,
  input wire sample_strobe,
  input wire [2:0] lowpass_setting_eff,
  input wire [1:0] rate_code,
  input wire [13:0] bandwidth_hz,
  input wire fifo_out_valid
);
  default clocking @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  sequence s_ar_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  sequence s_strobe;
    sample_strobe ##1 1'b1;
  endsequence
  a_read_answer: assert property (s_ar_taken |=> s_axi_rvalid) else $error("read not answered");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped");
  a_strobe_pulse: assert property (sample_strobe |=> !sample_strobe [*5]) else $error("strobe too long");
  a_out_capture: assert property (sample_strobe |=> rot_x_out[15:1] == $past(rot_x_in[15:1]))
    else $error("sample not captured");
  a_out_hold: assert property (!sample_strobe |=> $stable(rot_y_out)) else $error("output moved");
  a_fifo_write: assert property (s_strobe |-> fifo_out_valid) else $error("sample not queued");
  a_div_rate: assert property (lowpass_setting_eff inside {[3'h1:3'h6]} |-> rate_code == 2'h0)
    else $error("rate not 1k");
  a_fast_bw: assert property (rate_code == 2'h2 |-> lowpass_setting_eff == 3'h0 &&
    bandwidth_hz inside {14'h1FED, 14'h0CD1}) else $error("bypass bandwidth wrong");
  a_lpf0_bw: assert property (rate_code == 2'h1 && lowpass_setting_eff == 3'h0 |-> bandwidth_hz == 14'h00FA)
    else $error("setting 0 bandwidth wrong");
endmodule

bind srfc_top srfc_sva u_sva (.aclk(aclk), .aresetn(aresetn), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .rot_x_in(rot_x_in), .rot_x_out(rot_x_out), .rot_y_out(rot_y_out),
  .sample_strobe(sample_strobe), .lowpass_setting_eff(lowpass_setting_eff), .rate_code(rate_code),
  .bandwidth_hz(bandwidth_hz), .fifo_out_valid(fifo_out_valid));

//--- dv/srfc_host.sv
`timescale 1ns/1ns
// ============================================================
// Register host; it never assumes an answer time
module srfc_host (
  input wire aclk,
  output logic [7:0] awaddr,
  output logic awvalid,
  input wire awready,
  output logic [31:0] wdata,
  output logic [3:0] wstrb,
  output logic wvalid,
  input wire wready,
  input wire bvalid,
  output logic bready,
  output logic [7:0] araddr,
  output logic arvalid,
  input wire arready,
  input wire rvalid,
  output logic rready
);
  initial begin
    {awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
    {araddr, arvalid, rready} = '0;
  end
  task wr(input logic [7:0] a, input logic [31:0] d);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hF;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    @(posedge aclk);
    while (awvalid || wvalid || bready) begin
      if (awready)
        awvalid <= 1'b0;
      if (wready)
        wvalid <= 1'b0;
      if (bvalid)
        bready <= 1'b0;
      @(posedge aclk);
    end
  endtask
  task rd(input logic [7:0] a);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    @(posedge aclk);
    while (arvalid || rready) begin
      if (arready)
        arvalid <= 1'b0;
      if (rvalid)
        rready <= 1'b0;
      @(posedge aclk);
    end
  endtask
endmodule

//--- dv/sample_rate_filter_config_tb_top.sv
`timescale 1ns/1ns
`define CHK(n, e, s) begin samples_checked++; if ((e) !== (s)) begin bad_count++; \
  $display("[ERR] %s exp %h got %h", n, e, s); end end
// ============================================================
// Bench: short rate periods keep the run brief
module sample_rate_filter_config_tb_top;
  localparam int P1 = 50;
  localparam int P8 = 20;
  localparam int P32 = 10;
  localparam logic [13:0] BWT [8] = '{14'h00FA, 14'h00B0, 14'h005C, 14'h0029, 14'h0014, 14'h000A, 14'h0005, 14'h0CD1};
  localparam int PB [5] = '{0, 0, 1, 0, 2};
  localparam int PS [5] = '{1, 0, 3, 7, 4};
  localparam int PE [5] = '{3 * P1, P8, P32, P8, P32};
  localparam logic [33:0] ALL = 34'h3_FFFF_FFFF;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic sync_pin = 1'b0;
  logic fr = 1'b0;
  logic [127:0] din = 128'h0;
  logic [31:0] rs = 32'h579AD0C4;
  wire [111:0] dout, fd;
  wire [7:0] awaddr, araddr;
  wire [31:0] wdata, rdata;
  wire [3:0] wstrb;
  wire [1:0] bresp, rresp, rc;
  wire awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready, stb, fv;
  wire [2:0] lpe;
  wire [13:0] bw;
  int bad_count = 0;
  int samples_checked = 0;
  int cyc = 0;
  int n;
  logic [33:0] eq[$], mq[$], x, m;
  logic [1:0] bq[$];
  logic [111:0] fq[$], oe, f;
  logic [2:0] sel = 3'h0;
  logic [1:0] frm = 2'h1;
  logic pol = 1'b0, sv = 1'b0, pend = 1'b0;

  always #10 aclk = ~aclk;

  srfc_top #(.PER_1K(P1), .PER_8K(P8), .PER_32K(P32)) uut (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .frame_sync_input(sync_pin), .temp_in(din[15:0]), .rot_x_in(din[31:16]),
    .rot_y_in(din[47:32]), .rot_z_in(din[63:48]), .accel_x_in(din[79:64]), .accel_y_in(din[95:80]),
    .accel_z_in(din[111:96]), .temp_out(dout[15:0]), .rot_x_out(dout[31:16]), .rot_y_out(dout[47:32]),
    .rot_z_out(dout[63:48]), .accel_x_out(dout[79:64]), .accel_y_out(dout[95:80]),
    .accel_z_out(dout[111:96]), .sample_strobe(stb), .lowpass_setting_eff(lpe), .rate_code(rc),
    .bandwidth_hz(bw), .fifo_out_valid(fv), .fifo_out_ready(fr), .fifo_out_data(fd));

  srfc_host host (.aclk(aclk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
    .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bvalid(bvalid), .bready(bready), .araddr(araddr),
    .arvalid(arvalid), .arready(arready), .rvalid(rvalid), .rready(rready));

  function automatic logic [31:0] xs();
    rs ^= rs << 13;
    rs ^= rs >> 17;
    rs ^= rs << 5;
    return rs;
  endfunction
  function automatic logic [15:0] exp_rb(int b, int s);
    if (b[0])
      return {2'h2, 14'h1FED};
    if (b == 2)
      return {2'h2, 14'h0CD1};
    return {(s == 0 || s == 7) ? 2'h1 : 2'h0, BWT[s]};
  endfunction
  task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    bq.push_back(r);
    host.wr(a, d);
  endtask
  task rd(input logic [7:0] a, input logic [33:0] e, input logic [33:0] k);
    eq.push_back(e);
    mq.push_back(k);
    host.rd(a);
  endtask
  task wait_stb();
    do @(posedge aclk); while (stb !== 1'b1);
  endtask
  // Config writes start right after a strobe so the bench's copy never lags a capture
  task cfg(input logic [7:0] d);
    wait_stb();
    wr(8'h68, {24'h0, d}, 2'h0);
    sel <= d[5:3];
    pol <= d[6];
  endtask
  task per(output int c);
    wait_stb();
    c = 0;
    do begin
      @(posedge aclk);
      c++;
    end while (stb !== 1'b1);
  endtask
  task test_done();
    $display("checks %0d errors %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  always @(posedge aclk) begin
    din <= {xs(), xs(), xs(), xs()};
    fr <= frm[1] | (frm[0] & rs[0]);
    if (rvalid && rready) begin
      x = eq.pop_front();
      m = mq.pop_front();
      `CHK("rdata", x & m, {rresp, rdata} & m)
    end
    if (bvalid && bready) begin
      x[1:0] = bq.pop_front();
      `CHK("bresp", x[1:0], bresp)
    end
    if (fv && fr) begin
      f = fq.pop_front();
      `CHK("fifo", f, fd)
    end
    if (pend)
      `CHK("out", oe, dout)
    pend = stb;
    if (stb) begin
      oe = din[111:0];
      if (sel != 3'h0)
        oe[16 * sel - 16] = sv;
      if (fq.size() == 8 && !pol)
        void'(fq.pop_front());
      if (fq.size() < 8)
        fq.push_back(oe);
    end
    cyc++;
    if (cyc > 30000) begin
      bad_count++;
      test_done();
    end
  end

  initial begin
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(8'h64, 34'h0, ALL);
    rd(8'h68, 34'h0, ALL);
    rd(8'h6C, 34'h0, ALL);
    wr(8'h64, 32'h0000_0002, 2'h0);
    rd(8'h64, 34'h2, ALL);
    wr(8'h70, 32'h0000_0001, 2'h2);
    rd(8'h70, 34'h2_0000_0000, ALL);
    wr(8'h80, 32'hFFFF_FFFF, 2'h0);
    cfg(8'hFF);
    rd(8'h68, 34'h7F, ALL);
    // Every bypass and setting pair
    for (int b = 0; b < 4; b++) begin
      wr(8'h6C, 32'(b), 2'h0);
      for (int s = 0; s < 8; s++) begin
        cfg(8'(s));
        rd(8'h80, {18'h0, exp_rb(b, s)}, 34'h3_0000_FFFF);
        `CHK("rate_bw", exp_rb(b, s), {rc, bw})
        `CHK("lpf", (b == 0) ? 3'(s) : 3'h0, lpe)
      end
    end
    for (int i = 0; i < 5; i++) begin
      wr(8'h6C, 32'(PB[i]), 2'h0);
      cfg(8'(PS[i]));
      per(n);
      per(n);
      `CHK("period", PE[i], n)
    end
    wr(8'h6C, 32'h0, 2'h0);
    cfg(8'h00);
    sync_pin <= 1'b1;
    sv <= 1'b1;
    for (int k = 0; k < 8; k++) begin
      cfg(8'(k << 3));
      wait_stb();
    end
    sync_pin <= 1'b0;
    sv <= 1'b0;
    wait_stb();
    @(posedge aclk);
    sync_pin <= 1'b1;
    @(posedge aclk);
    sync_pin <= 1'b0;
    sv <= 1'b1;
    wait_stb();
    sv <= 1'b0;
    wait_stb();
    // Fill with the far side stalled, then drain at random pace
    cfg(8'h40);
    frm <= 2'h0;
    repeat (12) wait_stb();
    rd(8'h80, 34'h0_0804_0000, 34'h3_0F04_0000);
    frm <= 2'h1;
    while (fq.size() != 0) @(posedge aclk);
    cfg(8'h00);
    frm <= 2'h0;
    repeat (12) wait_stb();
    rd(8'h80, 34'h0_0800_0000, 34'h3_0F00_0000);
    frm <= 2'h1;
    while (fq.size() != 0) @(posedge aclk);
    test_done();
  end
endmodule
